// File: hdl/qpv_host.sv
// video source: power sequencing and data-enable-only quad pixel timing
// Behaviour
// - pixel clock 60 to 80 MHz, nominal 74.25
// - spread clock within 2 percent, 200 kHz
// - frame total 1115 to 1135 lines
// - exactly 1080 active lines per frame
// - vertical blank 35 to 55 lines, enable low
// - line total 540 to 575 clocks
// - enable high exactly 480 clocks per line
// - horizontal blank 60 to 95 clocks
// - refresh nominally 100 Hz or 120 Hz
// - inputs low while panel supply off
// - all signals driven while supply on
// - backlight on after panel, off first
// - channels A to D carry pixels 1 to 4
// - components are 10-bit unsigned grey levels
// - format select high VESA, low JEIDA
`timescale 1ns/10ps
`include "qpv_regs.svh"
module qpv_host #(
  parameter int H_BLANK      = `QPV_H_BLANK,
  parameter int V_BLANK      = `QPV_V_BLANK,
  parameter int PWR_ON_CYC   = `QPV_PWR_SETTLE_US * `QPV_CLK_SYS_MHZ,
  parameter int BL_ON_CYC    = `QPV_BL_ON_DELAY_US * `QPV_CLK_SYS_MHZ,
  parameter int BL_OFF_CYC   = `QPV_BL_OFF_DELAY_US * `QPV_CLK_SYS_MHZ,
  parameter int DISCHARGE_CYC = `QPV_DISCHARGE_US * `QPV_CLK_SYS_MHZ
) (
  input  wire logic         clk_sys,          // system clock, 50 MHz
  input  wire logic         rst,              // async reset, active high
  input  wire logic         enable,           // level: request panel on
  input  wire logic         cfgVesa,          // level: 1 VESA packing, 0 JEIDA
  output logic              panelPower_q,     // panel supply enable
  output logic              pixClkEnable_q,   // gate for the pixel clock driver
  output logic              formatSelect_q,   // format select pin
  output logic              backlight_q,      // backlight enable
  output logic              ready_q,          // panel lit and showing video
  input  wire logic         clk_pix,          // pixel clock, one per group of four
  input  wire logic [3:0][29:0] pixIn,        // pixel group, index 0 is channel A
  output logic              pixReq_q,         // present pixIn this cycle
  output logic              dataEnable_q,     // data enable pin
  output logic [3:0][29:0]  pixOut_q          // channel A..D pixel data
);

  localparam int HW = 10;
  localparam int VW = 11;
  // counter wide enough for the discharge wait at the default clock
  localparam int CW = 25;
  localparam int H_TOTAL = `QPV_H_ACTIVE + H_BLANK;
  localparam int V_TOTAL = `QPV_V_ACTIVE + V_BLANK;
  localparam logic [HW-1:0] H_ACT  = HW'(`QPV_H_ACTIVE);
  localparam logic [HW-1:0] H_LAST = HW'(H_TOTAL - 1);
  localparam logic [VW-1:0] V_ACT  = VW'(`QPV_V_ACTIVE);
  localparam logic [VW-1:0] V_LAST = VW'(V_TOTAL - 1);
  localparam logic [CW-1:0] PWR_ON_LD  = CW'(PWR_ON_CYC - 1);
  localparam logic [CW-1:0] BL_ON_LD   = CW'(BL_ON_CYC - 1);
  localparam logic [CW-1:0] BL_OFF_LD  = CW'(BL_OFF_CYC - 1);
  localparam logic [CW-1:0] DISCH_LD   = CW'(DISCHARGE_CYC - 1);
  localparam logic [CW-1:0] GUARD_LD   = CW'(`QPV_SYNC_GUARD);

  // ---------------- system domain: power sequencing ----------------
  typedef struct packed {
    qpv_pkg::qpv_seq_state_t st;
    logic [CW-1:0]           cnt;
    logic                    power;
    logic                    clkEn;
    logic                    fmt;
    logic                    run;
    logic                    bl;
    logic                    ready;
  } qpv_sys_t;

  qpv_sys_t sys_q;
  qpv_sys_t sys_d;
  logic     activeSync;
  logic     runSync;
  logic     pixActive;

  qpv_sync #(.W(1)) uActiveSync (
    .clk (clk_sys),
    .rst (rst),
    .d   (pixActive),
    .q   (activeSync)
  );

  always_comb begin
    sys_d = sys_q;
    unique case (sys_q.st)
      qpv_pkg::PWR_OFF: begin
        if (enable) begin
          // supply, clock and straps all driven in the same cycle
          sys_d.power = 1'b1;
          sys_d.clkEn = 1'b1;
          sys_d.fmt   = cfgVesa;
          sys_d.cnt   = PWR_ON_LD;
          sys_d.st    = qpv_pkg::PWR_UP;
        end
      end
      qpv_pkg::PWR_UP: begin
        if (sys_q.cnt == '0) begin
          sys_d.run = 1'b1;
          sys_d.st  = qpv_pkg::VID_UP;
        end else begin
          sys_d.cnt = sys_q.cnt - 1'b1;
        end
      end
      qpv_pkg::VID_UP: begin
        if (!enable) begin
          sys_d.run = 1'b0;
          sys_d.cnt = GUARD_LD;
          sys_d.st  = qpv_pkg::VID_DOWN;
        end else if (activeSync) begin
          sys_d.cnt = BL_ON_LD;
          sys_d.st  = qpv_pkg::BL_WAIT;
        end
      end
      qpv_pkg::BL_WAIT: begin
        if (!enable) begin
          sys_d.run = 1'b0;
          sys_d.cnt = GUARD_LD;
          sys_d.st  = qpv_pkg::VID_DOWN;
        end else if (sys_q.cnt == '0) begin
          // lamp only once the panel shows real frames
          sys_d.bl    = 1'b1;
          sys_d.ready = 1'b1;
          sys_d.st    = qpv_pkg::RUNNING;
        end else begin
          sys_d.cnt = sys_q.cnt - 1'b1;
        end
      end
      qpv_pkg::RUNNING: begin
        if (!enable) begin
          sys_d.bl    = 1'b0;
          sys_d.ready = 1'b0;
          sys_d.cnt   = BL_OFF_LD;
          sys_d.st    = qpv_pkg::BL_DOWN;
        end
      end
      qpv_pkg::BL_DOWN: begin
        if (sys_q.cnt == '0) begin
          sys_d.run = 1'b0;
          sys_d.cnt = GUARD_LD;
          sys_d.st  = qpv_pkg::VID_DOWN;
        end else begin
          sys_d.cnt = sys_q.cnt - 1'b1;
        end
      end
      qpv_pkg::VID_DOWN: begin
        // guard covers a run pulse still in flight through the crossings
        if (sys_q.cnt != '0) begin
          sys_d.cnt = sys_q.cnt - 1'b1;
        end else if (!activeSync) begin
          sys_d.clkEn = 1'b0;
          sys_d.fmt   = 1'b0;
          sys_d.power = 1'b0;
          sys_d.cnt   = DISCH_LD;
          sys_d.st    = qpv_pkg::PWR_DOWN;
        end
      end
      qpv_pkg::PWR_DOWN: begin
        // supply held off until the panel has discharged
        if (sys_q.cnt == '0) begin
          sys_d.st = qpv_pkg::PWR_OFF;
        end else begin
          sys_d.cnt = sys_q.cnt - 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sys_q <= '{st: qpv_pkg::PWR_OFF, default: '0};
    end else begin
      sys_q <= sys_d;
    end
  end

  assign panelPower_q   = sys_q.power;
  assign pixClkEnable_q = sys_q.clkEn;
  assign formatSelect_q = sys_q.fmt;
  assign backlight_q    = sys_q.bl;
  assign ready_q        = sys_q.ready;

  // ---------------- pixel domain: data enable timing ----------------
  typedef struct packed {
    logic             active;
    logic [HW-1:0]    hCnt;
    logic [VW-1:0]    vCnt;
    logic             req;
    logic             de;
    logic [3:0][29:0] pix;
  } qpv_pix_t;

  qpv_pix_t pix_q;
  qpv_pix_t pix_d;

  qpv_sync #(.W(1)) uRunSync (
    .clk (clk_pix),
    .rst (rst),
    .d   (sys_q.run),
    .q   (runSync)
  );

  always_comb begin
    pix_d     = pix_q;
    pix_d.req = pix_q.active && (pix_q.hCnt < H_ACT) && (pix_q.vCnt < V_ACT);
    pix_d.de  = pix_q.req;
    for (int i = 0; i < `QPV_CHANNELS; i++) begin
      // channel i carries pixel i+1 of the group; zeros outside enable
      pix_d.pix[i] = pix_q.req ? pixIn[i] : 30'h0000_0000;
    end
    if (!pix_q.active) begin
      pix_d.hCnt = '0;
      pix_d.vCnt = '0;
      pix_d.active = runSync;
    end else if (pix_q.hCnt == H_LAST) begin
      pix_d.hCnt = '0;
      if (pix_q.vCnt == V_LAST) begin
        pix_d.vCnt = '0;
        // stopping only at a frame boundary leaves no torn frame
        pix_d.active = runSync;
      end else begin
        pix_d.vCnt = pix_q.vCnt + 1'b1;
      end
    end else begin
      pix_d.hCnt = pix_q.hCnt + 1'b1;
    end
  end

  always_ff @(posedge clk_pix or posedge rst) begin
    if (rst) begin
      pix_q <= '0;
    end else begin
      pix_q <= pix_d;
    end
  end

  assign pixActive    = pix_q.active;
  assign pixReq_q     = pix_q.req;
  assign dataEnable_q = pix_q.de;
  assign pixOut_q     = pix_q.pix;

  // ---------------- checks ----------------
  localparam logic [20:0] H_ACT_L   = 21'(`QPV_H_ACTIVE);
  localparam logic [20:0] H_BLK_L   = 21'(H_BLANK);
  localparam logic [20:0] H_TOT_L   = 21'(H_TOTAL);
  localparam logic [20:0] V_GAP_L   = 21'(H_BLANK + V_BLANK * H_TOTAL);
  localparam logic [20:0] F_TOT_L   = 21'(V_TOTAL * H_TOTAL);
  localparam logic [VW-1:0] V_ACT_L = VW'(`QPV_V_ACTIVE);

  logic          deP;
  logic [20:0]   deLen;
  logic [20:0]   gapLen;
  logic [20:0]   lineLen;
  logic [20:0]   frameLen;
  logic [VW-1:0] lines;
  logic          seen;
  logic          started;
  logic          deRise;
  logic          frameRise;

  assign deRise    = dataEnable_q && !deP;
  // the first rise after start-up has no frame gap before it
  assign frameRise = deRise && (!started || gapLen > H_TOT_L);

  always_ff @(posedge clk_pix or posedge rst) begin
    if (rst) begin
      deP      <= 1'b0;
      deLen    <= '0;
      gapLen   <= '0;
      lineLen  <= '0;
      frameLen <= '0;
      lines    <= '0;
      seen     <= 1'b0;
      started  <= 1'b0;
    end else begin
      deP      <= dataEnable_q;
      deLen    <= dataEnable_q ? deLen + 1'b1 : '0;
      gapLen   <= dataEnable_q ? '0 : gapLen + 1'b1;
      lineLen  <= deRise ? 21'h00_0001 : lineLen + 1'b1;
      frameLen <= frameRise ? 21'h00_0001 : frameLen + 1'b1;
      lines    <= frameRise ? VW'(1) : (deRise ? lines + 1'b1 : lines);
      seen     <= pix_q.active && (seen || frameRise);
      started  <= pix_q.active && (started || deRise);
    end
  end

  a_de_width: assert property (@(posedge clk_pix) disable iff (rst)
    (deP && !dataEnable_q) |-> (deLen == H_ACT_L))
    else $error("data enable width not 480 clocks");

  a_hblank_len: assert property (@(posedge clk_pix) disable iff (rst)
    (deRise && !frameRise) |-> (gapLen == H_BLK_L))
    else $error("horizontal blank length wrong");

  a_line_total: assert property (@(posedge clk_pix) disable iff (rst)
    (deRise && !frameRise && seen) |-> (lineLen == H_TOT_L))
    else $error("line total wrong");

  a_frame_lines: assert property (@(posedge clk_pix) disable iff (rst)
    (frameRise && seen) |-> (lines == V_ACT_L))
    else $error("active line count wrong");

  a_line_count: assert property (@(posedge clk_pix) disable iff (rst)
    (deRise && !frameRise) |-> (lines < V_ACT_L))
    else $error("more active lines than a frame holds");

  a_vblank_len: assert property (@(posedge clk_pix) disable iff (rst)
    (frameRise && seen) |-> (gapLen == V_GAP_L))
    else $error("vertical blank length wrong");

  a_frame_total: assert property (@(posedge clk_pix) disable iff (rst)
    (frameRise && seen) |-> (frameLen == F_TOT_L))
    else $error("frame total wrong");

  a_chan_map: assert property (@(posedge clk_pix) disable iff (rst)
    pixReq_q |=> (dataEnable_q && pixOut_q == $past(pixIn)))
    else $error("channel data not taken in order");

  a_idle_quiet: assert property (@(posedge clk_pix) disable iff (rst)
    !dataEnable_q |-> (pixOut_q == '0))
    else $error("pixel data driven outside enable");

  a_bl_order: assert property (@(posedge clk_sys) disable iff (rst)
    backlight_q |-> (panelPower_q && activeSync && sys_q.run))
    else $error("backlight on without running panel");

  a_fmt_strap: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(panelPower_q) |-> (formatSelect_q == $past(cfgVesa)))
    else $error("format select not taken at power up");

  a_fmt_steady: assert property (@(posedge clk_sys) disable iff (rst)
    (panelPower_q && $past(panelPower_q)) |-> $stable(formatSelect_q))
    else $error("format select moved while powered");

  a_pwr_drive: assert property (@(posedge clk_sys) disable iff (rst)
    (sys_q.run || activeSync) |-> (panelPower_q && pixClkEnable_q))
    else $error("video driven without supply and clock");

endmodule

// File: hdl/qpv_regs.svh
// timing and sequencing constants for the quad pixel video source
`ifndef QPV_REGS_SVH
`define QPV_REGS_SVH

`define QPV_CLK_SYS_MHZ     50
`define QPV_COMP_BITS       10
`define QPV_CHANNELS        4
`define QPV_H_ACTIVE        480
`define QPV_H_BLANK         70
`define QPV_H_BLANK_MIN     60
`define QPV_H_BLANK_MAX     95
`define QPV_V_ACTIVE        1080
`define QPV_V_BLANK         45
`define QPV_V_BLANK_MIN     35
`define QPV_V_BLANK_MAX     55
`define QPV_PWR_SETTLE_US   20000
`define QPV_BL_ON_DELAY_US  10000
`define QPV_BL_OFF_DELAY_US 10000
`define QPV_DISCHARGE_US    500000
`define QPV_SYNC_GUARD      8'h08

`endif

// File: hdl/qpv_pkg.sv
// types shared by the quad pixel video source
package qpv_pkg;

  typedef enum logic [2:0] {
    PWR_OFF,
    PWR_UP,
    VID_UP,
    BL_WAIT,
    RUNNING,
    BL_DOWN,
    VID_DOWN,
    PWR_DOWN
  } qpv_seq_state_t;

endpackage

// File: hdl/qpv_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/10ps
module qpv_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,  // destination clock
  input  wire logic         rst,  // async reset, active high
  input  wire logic [W-1:0] d,    // level from the other domain
  output logic      [W-1:0] q     // synchronised level
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } qpv_sync_t;

  qpv_sync_t state_q;
  qpv_sync_t state_d;

  always_comb begin
    state_d        = state_q;
    state_d.meta   = d;
    state_d.stable = state_q.meta;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign q = state_q.stable;

endmodule

// File: dv/qpv_dv_pkg.sv
// pixel pattern shared by the bench driver and the panel model
package qpv_dv_pkg;
  function automatic logic [29:0] pix_word(input logic [15:0] ln, input logic [15:0] col, input int ch);
    logic [9:0] p;
    p = 10'(col * 4 + ch + 1);
    return {p, ln[9:0], ~p};
  endfunction
endpackage

// File: dv/qpv_panel_model.sv
// behavioural panel: counts lines from data enable and checks channel data
`timescale 1ns/10ps
module qpv_panel_model (
  input  wire logic             clk_pix,      // received pixel clock
  input  wire logic             panelPower,   // module supply
  input  wire logic             backlight,    // lamp enable
  input  wire logic             formatSelect, // packing select, observed only
  input  wire logic             dataEnable,   // data enable pin
  input  wire logic [3:0][29:0] pixOut,       // channels A..D
  output logic      [15:0]      lineCnt,      // lines this frame
  output logic      [15:0]      deRun,        // last enable-high run
  output logic      [15:0]      blankRun,     // last enable-low run
  output logic      [15:0]      pixErrs,      // pixel mismatches
  output logic      [15:0]      seqErrs       // pin state or order faults
);
  logic        deQ;
  logic [15:0] runCnt;
  logic [15:0] lowCnt;
  logic [15:0] col;
  logic [15:0] ln;
  logic [15:0] c;
  initial begin
    {deQ, runCnt, lowCnt, col, lineCnt, deRun, blankRun, pixErrs, seqErrs} = '0;
  end
  always @(posedge clk_pix) begin
    if ((!panelPower || lineCnt == 16'h0000) && backlight) seqErrs <= seqErrs + 16'h0001;
    if (!panelPower) begin
      if (dataEnable || formatSelect || (|pixOut)) seqErrs <= seqErrs + 16'h0001;
      {deQ, runCnt, lowCnt, col, lineCnt} <= '0;
    end else begin
      ln = lineCnt;
      c = col;
      // no sync pins: a long low gap is the only frame marker
      if (dataEnable && !deQ) begin
        ln = (lowCnt > 16'h044C) ? 16'h0001 : lineCnt + 16'h0001;
        c = 16'h0000;
        blankRun <= lowCnt;
      end
      deQ <= dataEnable;
      lineCnt <= ln;
      if (dataEnable) begin
        // data is taken only in enable-high clocks
        for (int i = 0; i < 4; i++) begin
          if (pixOut[i] !== qpv_dv_pkg::pix_word(ln, c, i)) pixErrs <= pixErrs + 16'h0001;
        end
        runCnt <= runCnt + 16'h0001;
        lowCnt <= 16'h0000;
        col <= c + 16'h0001;
      end else begin
        if (deQ) deRun <= runCnt;
        runCnt <= 16'h0000;
        lowCnt <= lowCnt + 16'h0001;
      end
    end
  end
endmodule

// File: dv/qpv_host_tb.sv
// self-checking bench for the quad pixel video source
`timescale 1ns/10ps
module qpv_host_tb;
  localparam int HB    = 32'h3C;
  localparam int SHORT = 32'h14;
  logic             clk_sys;
  logic             clk_pix;
  logic             rst;
  logic             enable;
  logic             cfgVesa;
  logic             panelPower_q;
  logic             pixClkEnable_q;
  logic             formatSelect_q;
  logic             backlight_q;
  logic             ready_q;
  logic             pixReq_q;
  logic             dataEnable_q;
  logic [3:0][29:0] pixIn;
  logic [3:0][29:0] pixOut_q;
  logic [15:0]      lineCnt;
  logic [15:0]      deRun;
  logic [15:0]      blankRun;
  logic [15:0]      pixErrs;
  logic [15:0]      seqErrs;
  logic [15:0]      bLine;
  logic [15:0]      bCol;
  logic             reqQ;
  int               fails;
  int               n_tests;

  qpv_host #(.H_BLANK(HB), .V_BLANK(32'h23), .PWR_ON_CYC(SHORT), .BL_ON_CYC(SHORT), .BL_OFF_CYC(SHORT),
    .DISCHARGE_CYC(SHORT)) DUT (.clk_sys(clk_sys), .rst(rst), .enable(enable), .cfgVesa(cfgVesa),
    .panelPower_q(panelPower_q), .pixClkEnable_q(pixClkEnable_q), .formatSelect_q(formatSelect_q),
    .backlight_q(backlight_q), .ready_q(ready_q), .clk_pix(clk_pix), .pixIn(pixIn), .pixReq_q(pixReq_q),
    .dataEnable_q(dataEnable_q), .pixOut_q(pixOut_q));

  qpv_panel_model panel (.clk_pix(clk_pix), .panelPower(panelPower_q), .backlight(backlight_q),
    .formatSelect(formatSelect_q), .dataEnable(dataEnable_q), .pixOut(pixOut_q), .lineCnt(lineCnt),
    .deRun(deRun), .blankRun(blankRun), .pixErrs(pixErrs), .seqErrs(seqErrs));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    clk_pix = 1'b0;
    #7;
    forever #16 clk_pix = ~clk_pix;
  end

  // source side: a fresh group per request, changing junk in blank clocks
  always @(posedge clk_pix) begin
    #1;
    if (panelPower_q !== 1'b1) bLine = 16'h0000;
    if (pixReq_q === 1'b1) begin
      bCol = reqQ ? bCol + 16'h0001 : 16'h0000;
      if (!reqQ) bLine = bLine + 16'h0001;
      for (int i = 0; i < 4; i++) pixIn[i] = qpv_dv_pkg::pix_word(bLine, bCol, i);
    end else begin
      pixIn = ~pixIn;
    end
    reqQ = (pixReq_q === 1'b1);
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic sys_cycles(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic give_up(input string msg);
    fails++;
    $display("wrong value at %0t: %s timed out", $time, msg);
    close_out();
  endtask

  task automatic t_reset();
    rst = 1'b1;
    enable = 1'b0;
    sys_cycles(16);
    rst = 1'b0;
    sys_cycles(1);
    check(32'({panelPower_q, pixClkEnable_q, formatSelect_q, backlight_q, ready_q, dataEnable_q}), 32'h0,
      "outputs after reset");
    $display("test reset done");
  endtask

  task automatic t_power_on(input logic vesa);
    int i;
    cfgVesa = vesa;
    enable = 1'b1;
    sys_cycles(2);
    check(32'({panelPower_q, pixClkEnable_q, backlight_q}), 32'h6, "supply before lamp");
    check(32'(formatSelect_q), 32'(vesa), "format pin");
    for (i = 0; i < 4000 && ready_q !== 1'b1; i++) sys_cycles(1);
    if (i == 4000) give_up("ready");
    check(32'(backlight_q), 32'h1, "lamp with ready");
    check(32'(seqErrs), 32'h0, "lamp only after video");
    $display("test power on done");
  endtask

  task automatic t_lines();
    int i;
    for (i = 0; i < 8000 && lineCnt < 16'h0004; i++) sys_cycles(1);
    if (i == 8000) give_up("lines");
    check(32'(deRun), 32'h1E0, "active clocks");
    check(32'(blankRun), 32'(HB), "blank clocks");
    check(32'(deRun) + 32'(blankRun), 32'h21C, "line total");
    check(32'(lineCnt), 32'(bLine), "lines from enable edges");
    check(32'(pixErrs), 32'h0, "channel data");
    $display("test lines done");
  endtask

  task automatic t_power_off();
    enable = 1'b0;
    sys_cycles(2);
    check(32'({backlight_q, ready_q, panelPower_q}), 32'h1, "lamp off first");
    sys_cycles(40);
    check(32'(panelPower_q), 32'h1, "supply held in frame");
    $display("test power off done");
  endtask

  initial begin
    rst = 1'b1;
    enable = 1'b0;
    cfgVesa = 1'b0;
    pixIn = '0;
    bLine = 16'h0000;
    bCol = 16'h0000;
    reqQ = 1'b0;
    fails = 0;
    n_tests = 0;
    t_reset();
    t_power_on(1'b1);
    t_lines();
    t_power_off();
    // second reset lands mid-frame with the lamp off
    t_reset();
    t_power_on(1'b0);
    t_lines();
    check(32'(seqErrs), 32'h0, "pins with supply off");
    close_out();
  end
endmodule
